// ==== adc_out_checker.sv ====
`timescale 1ns/1ns
module adc_out_checker (
    input wire        clk_sys,
    input wire        rst,
    input wire        conv_clock_pos,
    input wire [14:0] sample_word_r,
    input wire        sample_bit_lsb,
    input wire        sample_bit_msb,
    input wire        overrange_flag_r,
    input wire        sample_valid_strobe_r
);
    // ==========
    // Output timing and values
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (rst);
    wire        s = sample_valid_strobe_r;
    wire        f = overrange_flag_r;
    wire        p = conv_clock_pos;
    wire [14:0] w = sample_word_r;
    a_lsb_line: assert property (sample_bit_lsb == w[0])
        else $error("lsb");
    a_msb_line: assert property (sample_bit_msb == w[14])
        else $error("msb");
    a_out_update: assert property (!$stable({w, f}) |-> !s)
        else $error("update");
    a_hold_word: assert property ($rose(s) |=> $stable({w, f}) [*8])
        else $error("hold");
    a_flag_sat: assert property (f |-> w == 15'h3FFF || w == 15'h4000)
        else $error("sat");
    a_strobe_late: assert property ($rose(s) |-> !p && !$past(p, 4))
        else $error("late");
    a_strobe_due: assert property ($fell(p) |-> ##[3:12] $rose(s))
        else $error("due");
    a_rise_sample: assert property ($rose(p) |-> ##[3:8] !s)
        else $error("rise");
    c_strobe: cover property ($rose(s));
    c_over_pos: cover property (f && !w[14]);
    c_over_neg: cover property (f && w[14]);
endmodule
bind adc_parallel_sample_output adc_out_checker u_adc_out_checker (
    .clk_sys, .rst, .conv_clock_pos, .sample_word_r, .sample_bit_lsb,
    .sample_bit_msb, .overrange_flag_r, .sample_valid_strobe_r);

// ==== adc_out_defs.vh ====
`ifndef ADC_OUT_DEFS_VH
`define ADC_OUT_DEFS_VH

// ============================================================
// Word format
`define SAMPLE_W        15
`define SAMPLE_MSB      14
`define SAMPLE_LSB      0
`define ANALOG_W        16
`define DIFF_W          17
`define FS_POS          17'h03FFF
`define FS_NEG          17'h1C000
`define WORD_RST        15'h0000

// ============================================================
// Pipeline and timing
`define LATENCY_STAGES  3
`define CLK_PERIOD_PS   4000
`define STROBE_DLY_PS   6500
`define STROBE_DLY_CYC  ((`STROBE_DLY_PS / `CLK_PERIOD_PS) > 0 ? \
                         (`STROBE_DLY_PS / `CLK_PERIOD_PS) : 1)
`define DLY_CNT_W       3
`define SYNC_STAGES     3

`endif

// ==== adc_parallel_sample_output.v ====
`timescale 1ns/1ns
`include "adc_out_defs.vh"

module adc_parallel_sample_output (
    input  wire                    clk_sys,
    input  wire                    rst,
    input  wire                    conv_clock_pos,
    input  wire                    conv_clock_neg,
    input  wire [`ANALOG_W-1:0]    analog_in_pos,
    input  wire [`ANALOG_W-1:0]    analog_in_neg,
    output reg  [`SAMPLE_W-1:0]    sample_word_r,
    output wire                    sample_bit_lsb,
    output wire                    sample_bit_msb,
    output reg                     overrange_flag_r,
    output reg                     sample_valid_strobe_r
);

// ============================================================
// Converter clock edge detection
wire pos_lvl;
wire neg_lvl;
wire conv_valid;
reg  conv_lvl_r;
reg  conv_lvl_nxt;
reg  conv_prev_r;
wire conv_rise;
wire conv_fall;

pin_sync_filter u_sync_pos (
    .clk_sys (clk_sys),
    .rst     (rst),
    .pin_in  (conv_clock_pos),
    .level_r (pos_lvl)
);

pin_sync_filter u_sync_neg (
    .clk_sys (clk_sys),
    .rst     (rst),
    .pin_in  (conv_clock_neg),
    .level_r (neg_lvl)
);

// Level only trusted while the two pins disagree
assign conv_valid = pos_lvl ^ neg_lvl;

always @* begin
    conv_lvl_nxt = conv_lvl_r;
    if (conv_valid) begin
        conv_lvl_nxt = pos_lvl;
    end
end

always @(posedge clk_sys) begin
    if (rst) begin
        conv_lvl_r  <= 1'b0;
        conv_prev_r <= 1'b0;
    end else begin
        conv_lvl_r  <= conv_lvl_nxt;
        conv_prev_r <= conv_lvl_r;
    end
end

// ============================================================
// Edge strobes, one cycle each
assign conv_rise = conv_lvl_r & ~conv_prev_r;
assign conv_fall = ~conv_lvl_r & conv_prev_r;

// ============================================================
// Quantizer: difference, saturation and overrange
wire signed [`DIFF_W-1:0]   diff;
wire signed [`DIFF_W-1:0]   fs_pos;
wire signed [`DIFF_W-1:0]   fs_neg;
wire        [`SAMPLE_W-1:0] code_hi;
wire        [`SAMPLE_W-1:0] code_lo;
wire                        above_fs;
wire                        below_fs;
reg         [`SAMPLE_W-1:0] code;
reg                         over;

assign diff     = $signed({analog_in_pos[`ANALOG_W-1], analog_in_pos})
                - $signed({analog_in_neg[`ANALOG_W-1], analog_in_neg});
assign fs_pos   = `FS_POS;
assign fs_neg   = `FS_NEG;
assign code_hi  = fs_pos[`SAMPLE_W-1:0];
assign code_lo  = fs_neg[`SAMPLE_W-1:0];
assign above_fs = (diff > fs_pos);
assign below_fs = (diff < fs_neg);

always @* begin
    if (above_fs) begin
        code = code_hi;
        over = 1'b1;
    end else if (below_fs) begin
        code = code_lo;
        over = 1'b1;
    end else begin
        code = diff[`SAMPLE_W-1:0];
        over = 1'b0;
    end
end

// ============================================================
// Latency pipeline
wire [`SAMPLE_W-1:0] tail_word;
wire                 tail_over;

genvar g;
generate
    for (g = 0; g < `LATENCY_STAGES; g = g + 1) begin : g_stage
        wire [`SAMPLE_W-1:0] word_in;
        wire                 over_in;
        reg  [`SAMPLE_W-1:0] word_r;
        reg                  over_r;
        if (g == 0) begin : g_head
            assign word_in = code;
            assign over_in = over;
        end else begin : g_link
            assign word_in = g_stage[g-1].word_r;
            assign over_in = g_stage[g-1].over_r;
        end
        always @(posedge clk_sys) begin
            if (rst) begin
                word_r <= `WORD_RST;
                over_r <= 1'b0;
            end else if (conv_rise) begin
                word_r <= word_in;
                over_r <= over_in;
            end
        end
    end
endgenerate

assign tail_word = g_stage[`LATENCY_STAGES-1].word_r;
assign tail_over = g_stage[`LATENCY_STAGES-1].over_r;

// ============================================================
// Output register
reg [`SAMPLE_W-1:0] word_nxt;
reg                 flag_nxt;

always @* begin
    word_nxt = sample_word_r;
    flag_nxt = overrange_flag_r;
    if (conv_rise) begin
        word_nxt = tail_word;
        flag_nxt = tail_over;
    end
end

always @(posedge clk_sys) begin
    if (rst) begin
        sample_word_r    <= `WORD_RST;
        overrange_flag_r <= 1'b0;
    end else begin
        sample_word_r    <= word_nxt;
        overrange_flag_r <= flag_nxt;
    end
end

assign sample_bit_lsb = sample_word_r[`SAMPLE_LSB];
assign sample_bit_msb = sample_word_r[`SAMPLE_MSB];

// ============================================================
// Valid strobe delay counter
localparam integer          DLY_CYC_I = `STROBE_DLY_CYC;
localparam [`DLY_CNT_W-1:0] DLY_CYC   = DLY_CYC_I[`DLY_CNT_W-1:0];
reg [`DLY_CNT_W-1:0] dly_cnt_r;
reg [`DLY_CNT_W-1:0] dly_cnt_nxt;

always @* begin
    dly_cnt_nxt = dly_cnt_r;
    if (conv_fall) begin
        dly_cnt_nxt = DLY_CYC;
    end else if (dly_cnt_r != 3'h0) begin
        dly_cnt_nxt = dly_cnt_r - 3'h1;
    end
end

always @(posedge clk_sys) begin
    if (rst) begin
        dly_cnt_r <= 3'h0;
    end else begin
        dly_cnt_r <= dly_cnt_nxt;
    end
end

// ============================================================
// Valid strobe after falling edge
reg strobe_nxt;

always @* begin
    strobe_nxt = sample_valid_strobe_r;
    if (dly_cnt_r == 3'h1 && !conv_fall) begin
        strobe_nxt = 1'b1;
    end else if (conv_rise) begin
        strobe_nxt = 1'b0;
    end
end

always @(posedge clk_sys) begin
    if (rst) begin
        sample_valid_strobe_r <= 1'b0;
    end else begin
        sample_valid_strobe_r <= strobe_nxt;
    end
end

endmodule

// ==== pin_sync_filter.v ====
`timescale 1ns/1ns
`include "adc_out_defs.vh"

module pin_sync_filter (
    input  wire clk_sys,
    input  wire rst,
    input  wire pin_in,
    output reg  level_r
);

// ============================================================
// Three-stage sampler, accept when stages two and three agree
reg [`SYNC_STAGES-1:0] stage_r;

always @(posedge clk_sys) begin
    if (rst) begin
        stage_r <= 3'h0;
        level_r <= 1'b0;
    end else begin
        stage_r <= {stage_r[1:0], pin_in};
        if (stage_r[1] == stage_r[2]) begin
            level_r <= stage_r[2];
        end
    end
end

endmodule

// ==== sample_capture.sv ====
`timescale 1ns/1ns
module sample_capture (
    input  wire        sample_valid_strobe_r,
    input  wire [14:0] sample_word_r,
    input  wire        overrange_flag_r,
    output reg  [14:0] cap_word_r,
    output reg         cap_flag_r
);
    always @(posedge sample_valid_strobe_r) begin
        cap_word_r <= sample_word_r;
        cap_flag_r <= overrange_flag_r;
    end
endmodule

// ==== tb_top.sv ====
`timescale 1ns/1ns
module tb_top;
`define CHK(a, b) begin checks++; if ((a) !== (b)) begin errors++; \
  $display("CHECK FAILED t=%0t got=%h exp=%h", $time, a, b); end end
    reg         clk_sys = 0, rst = 1, conv_clock_pos = 0, conv_clock_neg = 1;
    reg  [15:0] analog_in_pos = 0, analog_in_neg = 0, q[$];
    wire [14:0] sample_word_r, cap_word_r;
    wire        sample_bit_lsb, sample_bit_msb, overrange_flag_r;
    wire        sample_valid_strobe_r, cap_flag_r;
    int         errors = 0, checks = 0;
    always #2 clk_sys = ~clk_sys;
    adc_parallel_sample_output u_adc_parallel_sample_output (.clk_sys, .rst,
        .conv_clock_pos, .conv_clock_neg, .analog_in_pos, .analog_in_neg,
        .sample_word_r, .sample_bit_lsb, .sample_bit_msb, .overrange_flag_r,
        .sample_valid_strobe_r);
    sample_capture u_sample_capture (.sample_valid_strobe_r, .sample_word_r,
        .overrange_flag_r, .cap_word_r, .cap_flag_r);
    // ==========
    // One converter period, checks the word taken three periods back
    task cyc(input [15:0] a, input [15:0] b);
        reg signed [16:0] d;
        reg        [15:0] e;
        d = $signed({a[15], a}) - $signed({b[15], b});
        e = d > 17'sd16383 ? 16'hBFFF : d < -17'sd16384 ? 16'hC000 :
            {1'b0, d[14:0]};
        q.push_back(e);
        @(negedge clk_sys);
        {analog_in_pos, analog_in_neg} = {a, b};
        {conv_clock_pos, conv_clock_neg} = 2'h2;
        repeat (20) @(negedge clk_sys);
        {conv_clock_pos, conv_clock_neg} = 2'h1;
        repeat (19) @(negedge clk_sys);
        if (q.size() > 3) begin
            e = q.pop_front();
            `CHK({cap_flag_r, cap_word_r}, e)
            `CHK({sample_bit_msb, sample_bit_lsb}, {e[14], e[0]})
        end
    endtask
    // ==========
    // Scenarios
    task t_codes;
        cyc(16'h0000, 16'h0000);
        cyc(16'h0001, 16'h0000);
        cyc(16'h0000, 16'h0001);
        cyc(16'h3FFF, 16'h0000);
        cyc(16'h0000, 16'h4000);
        repeat (3) cyc(16'h0000, 16'h0000);
    endtask
    task t_over;
        cyc(16'h4000, 16'h0000);
        cyc(16'h7FFF, 16'h8000);
        cyc(16'hBFFF, 16'h0000);
        cyc(16'h8000, 16'h7FFF);
        cyc(16'h0001, 16'h0001);
        repeat (3) cyc(16'h0000, 16'h0000);
    endtask
    task end_sim;
        $display("errors=%0d checks=%0d", errors, checks);
        if (errors == 0 && checks > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask
    initial begin
        #20000;
        errors++;
        end_sim;
    end
    initial begin
        repeat (20) @(negedge clk_sys);
        rst = 0;
        repeat (4) @(negedge clk_sys);
        t_codes;
        t_over;
        end_sim;
    end
endmodule
